//--- rtl/csp_pkg.sv
/*
 * Shared constants and types for the codec serial audio/control port:
 * timing, frame layout, register addresses, reset values and carriers.
 * Assumes a 100 MHz core clock and a 10.24 MHz oscillator clock.
 */
`default_nettype none

package csp_pkg;

	// Core clock and power-on timing
	localparam int unsigned CORE_HZ      = 100_000_000;
	localparam int unsigned POR_VALID_MS = 100;
	localparam int unsigned POR_VALID_CYC = CORE_HZ / 1000 * POR_VALID_MS;
	localparam int unsigned BROWN_US     = 44;
	localparam int unsigned BROWN_CYC    = CORE_HZ / 1_000_000 * BROWN_US;

	// Oscillator divides: /8 gives the 1.28 MHz shift clock
	localparam logic [2:0] DIV_SHIFT  = 3'h0;
	localparam logic [2:0] DIV_HALF   = 3'h4;
	localparam logic [2:0] DIV_SAMPLE = 3'h7;
	localparam logic [2:0] DIV_STEP   = 3'h1;

	// Bit slots within a 32-slot frame
	localparam logic [4:0] BIT_FIRST  = 5'h00;
	localparam logic [4:0] BIT_STEP   = 5'h01;
	localparam logic [4:0] BIT_HALF   = 5'h10;
	localparam logic [4:0] BIT_SNAP   = 5'h18;
	localparam logic [4:0] BIT_LAST   = 5'h1F;
	localparam logic [4:0] PRE_PULSE  = 5'h03;
	localparam logic [4:0] PRE_LAST   = 5'h07;

	// Word widths and positions in the received frame
	localparam int unsigned ADC_W  = 16;
	localparam int unsigned DAC_W  = 20;
	localparam int unsigned RESP_W = 8;
	localparam int unsigned RX_AUDIO_LSB = 12;
	localparam int unsigned RX_S16_LSB   = 16;
	localparam logic [7:0]  PAD_BYTE     = 8'h00;

	// Register addresses
	localparam logic [2:0] ADDR_NONE   = 3'h0;
	localparam logic [2:0] ADDR_PGAC   = 3'h1;
	localparam logic [2:0] ADDR_HPFSFT = 3'h2;
	localparam logic [2:0] ADDR_PDC    = 3'h3;
	localparam logic [2:0] ADDR_FASTAR = 3'h4;
	localparam logic [2:0] ADDR_SLOWAR = 3'h5;

	// Reset values and implemented-bit masks
	localparam logic [7:0] RST_PGAC   = 8'h46;
	localparam logic [7:0] RST_HPFSFT = 8'h11;
	localparam logic [7:0] RST_PDC    = 8'h00;
	localparam logic [7:0] RST_FASTAR = 8'hF7;
	localparam logic [7:0] RST_SLOWAR = 8'h00;
	localparam logic [7:0] MASK_ALL   = 8'hFF;
	localparam logic [7:0] READ_ZERO  = 8'h00;

	// Field positions
	localparam int unsigned PGAC_RDMODE_BIT = 7;
	localparam int unsigned SHIFT_LSB       = 2;
	localparam logic [2:0]  SHIFT_MAX       = 3'h5;

	typedef enum logic [1:0] {
		DAC_OFF  = 2'h0,
		DAC_16   = 2'h1,
		DAC_20   = 2'h2,
		DAC_LOOP = 2'h3
	} csp_dac_mode_e;

	typedef enum logic [2:0] {
		LK_IDLE = 3'h1,
		LK_PRE  = 3'h2,
		LK_RUN  = 3'h4
	} csp_link_e;

	typedef struct packed {
		logic [7:0] pgac;
		logic [7:0] hpfsft;
		logic [7:0] pdc;
		logic [7:0] fastar;
		logic [7:0] slowar;
	} csp_regs_s;

	// Control word: direction (1 = write), address, content
	typedef struct packed {
		logic       rw;
		logic [2:0] addr;
		logic [7:0] data;
	} csp_ctrl_s;

endpackage

`default_nettype wire

//--- rtl/csp_port.sv
/*
 * Master serial audio/control port of a voice-band codec: link framing on
 * the oscillator clock, register file, modulator feed and power-on gating
 * on the core clock.
 * Assumes osc_clk is the free-running 10.24 MHz oscillator, that converter
 * samples arrive on core_clk, and that pins are asynchronous to both.
 */
`default_nettype none

// Behaviour
// - Pin low selects codec framing, high SPI.
// - Send 16-bit sample, take 20-bit sample.
// - Five eight-bit user registers, read and write.
// - Unused register bits always read zero; here every read mask is MASK_ALL, so all bits read back as written except PGAC bits 6:0 while PGAC bit 7 is set.
// - Drive bit clock and frame; frame resynchronises.
// - Codec framing runs as link master.
// - Codec framing: 1.28 MHz clock, 40 kHz frame.
// - Input frame: 20-bit audio plus 12-bit control.
// - Modulator path supports 20-bit and 16-bit widths.
// - Control word: direction, three address, eight data.
// - Zero address means no register access.
// - Output frame: 16-bit sample then 8-bit response.
// - All words shifted most significant bit first.
// - SPI framing: master driving 1.28 MHz clock.
// - SPI frame line low throughout transfer.
// - Eight idle SPI clocks with slave reset pulse.
// - Each SPI frame: 16 bits out, 20 in.
// - SPI register access spans two frames.
// - SPI zero address audio only; else next frame.
// - Port idle until supply valid for 100 ms.
// - Gate modulator after 44 us supply drop.
// - Free-running balanced clock output for external use.
// - Mode field: off, shifted 16, raw 20, loopback.
module csp_port #(
	parameter int unsigned POR_VALID_CYCLES = csp_pkg::POR_VALID_CYC,
	parameter int unsigned BROWN_CYCLES     = csp_pkg::BROWN_CYC
) (
	// Clocks and reset
	input  wire logic                     core_clk,
	input  wire logic                     osc_clk,
	input  wire logic                     sys_rst,
	// Link pins
	input  wire logic                     protocol_select_pin,
	input  wire logic                     serial_input_line,
	output logic                          sclk,
	output logic                          frame_sync,
	output logic                          serial_output_line,
	output logic                          mclk,
	// Converter side
	input  wire logic [csp_pkg::ADC_W-1:0] adc_data,
	input  wire logic                     adc_valid,
	input  wire logic [6:0]               pgac_gain_actual,
	input  wire logic                     supply_low,
	output logic [csp_pkg::DAC_W-1:0]     dac_data,
	output logic                          dac_valid,
	output logic                          modulator_gate,
	output logic                          port_active,
	output var csp_pkg::csp_regs_s        regs
);

	// Sign-extend, shift left and clamp a 16-bit sample to 20 bits
	function automatic logic [19:0] shift_sample(input logic [15:0] s,
		input logic [2:0] sh);
		logic [20:0] ext;
		logic [20:0] prod;
		logic [2:0]  eff;
		ext  = {{5{s[15]}}, s};
		eff  = (sh > csp_pkg::SHIFT_MAX) ? csp_pkg::SHIFT_MAX : sh;
		prod = ext << eff;
		if (prod[20] != prod[19])
			shift_sample = {prod[20], {19{~prod[20]}}};
		else
			shift_sample = prod[19:0];
	endfunction

	// Register read with the gain read-back option
	function automatic logic [7:0] read_reg(input csp_pkg::csp_regs_s r,
		input logic [2:0] a, input logic [6:0] gain);
		case (a)
			csp_pkg::ADDR_PGAC:
				read_reg = r.pgac[csp_pkg::PGAC_RDMODE_BIT] ?
					{r.pgac[csp_pkg::PGAC_RDMODE_BIT], gain} : r.pgac;
			csp_pkg::ADDR_HPFSFT: read_reg = r.hpfsft & csp_pkg::MASK_ALL;
			csp_pkg::ADDR_PDC:    read_reg = r.pdc & csp_pkg::MASK_ALL;
			csp_pkg::ADDR_FASTAR: read_reg = r.fastar & csp_pkg::MASK_ALL;
			csp_pkg::ADDR_SLOWAR: read_reg = r.slowar & csp_pkg::MASK_ALL;
			default:              read_reg = csp_pkg::READ_ZERO;
		endcase
	endfunction

	// Link domain (osc_clk)
	logic               psel_m, psel_s, serial_input_line_m, serial_input_line_s, act_m, act_s;
	logic [2:0]         div;
	logic [2:0]         next_div;
	logic [4:0]         bit_cnt;
	logic               mode_spi;
	logic               frame_tog;
	logic [31:0]        tx_sh, rx_sh, rx_word;
	logic [15:0]        snap_audio;
	logic [7:0]         snap_resp;
	csp_pkg::csp_link_e state;
	logic               tick_shift, tick_samp;
	logic [15:0]        adc_hold, tx_audio;
	logic [7:0]         resp;

	assign next_div   = div + csp_pkg::DIV_STEP;
	assign tick_shift = (div == csp_pkg::DIV_SHIFT);
	assign tick_samp  = (div == csp_pkg::DIV_SAMPLE);

	always_ff @(posedge osc_clk or posedge sys_rst) begin
		if (sys_rst) begin
			psel_m <= 1'b0;
			psel_s <= 1'b0;
			serial_input_line_m <= 1'b0;
			serial_input_line_s <= 1'b0;
			act_m  <= 1'b0;
			act_s  <= 1'b0;
		end else begin
			psel_m <= protocol_select_pin;
			psel_s <= psel_m;
			serial_input_line_m <= serial_input_line;
			serial_input_line_s <= serial_input_line_m;
			act_m  <= port_active;
			act_s  <= act_m;
		end
	end

	// Oscillator divider and balanced clock output
	always_ff @(posedge osc_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div  <= 3'h0;
			mclk <= 1'b0;
		end else begin
			div  <= next_div;
			mclk <= ~mclk;
		end
	end

	// Framing sequencer; a mode change or loss of power-valid resyncs
	always_ff @(posedge osc_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state    <= csp_pkg::LK_IDLE;
			bit_cnt  <= csp_pkg::BIT_FIRST;
			mode_spi <= 1'b0;
		end else if (tick_samp) begin
			case (state)
				csp_pkg::LK_IDLE: begin
					bit_cnt  <= csp_pkg::BIT_FIRST;
					mode_spi <= psel_s;
					if (act_s)
						state <= psel_s ? csp_pkg::LK_PRE : csp_pkg::LK_RUN;
				end
				csp_pkg::LK_PRE: begin
					if (bit_cnt == csp_pkg::PRE_LAST) begin
						bit_cnt <= csp_pkg::BIT_FIRST;
						state   <= csp_pkg::LK_RUN;
					end else
						bit_cnt <= bit_cnt + csp_pkg::BIT_STEP;
				end
				csp_pkg::LK_RUN: begin
					bit_cnt <= bit_cnt + csp_pkg::BIT_STEP;
					if (bit_cnt == csp_pkg::BIT_LAST &&
						(!act_s || psel_s != mode_spi))
						state <= csp_pkg::LK_IDLE;
				end
				default: state <= csp_pkg::LK_IDLE;
			endcase
		end
	end

	// Shift clock: low half then high half of each slot
	always_ff @(posedge osc_clk or posedge sys_rst) begin
		if (sys_rst)
			sclk <= 1'b0;
		else
			sclk <= (state != csp_pkg::LK_IDLE) &&
				(next_div >= csp_pkg::DIV_HALF);
	end

	// Frame line
	always_ff @(posedge osc_clk or posedge sys_rst) begin
		if (sys_rst)
			frame_sync <= 1'b0;
		else if (state == csp_pkg::LK_IDLE)
			frame_sync <= psel_s;
		else if (tick_shift) begin
			if (state == csp_pkg::LK_PRE)
				frame_sync <= (bit_cnt == csp_pkg::PRE_PULSE);
			else if (mode_spi)
				frame_sync <= 1'b0;
			else
				frame_sync <= (bit_cnt < csp_pkg::BIT_HALF);
		end
	end

	// Core values are frozen at slot 24 of the frame, far from their update point
	always_ff @(posedge osc_clk or posedge sys_rst) begin
		if (sys_rst) begin
			snap_audio <= 16'h0000;
			snap_resp  <= 8'h00;
		end else if (state == csp_pkg::LK_IDLE ||
			(tick_shift && bit_cnt == csp_pkg::BIT_SNAP)) begin
			snap_audio <= tx_audio;
			snap_resp  <= resp;
		end
	end

	// Transmit: sample, response, pad; MSB first
	always_ff @(posedge osc_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_sh              <= 32'h0000_0000;
			serial_output_line <= 1'b0;
		end else if (state != csp_pkg::LK_RUN)
			serial_output_line <= 1'b0;
		else if (tick_shift) begin
			if (bit_cnt == csp_pkg::BIT_FIRST) begin
				tx_sh <= {snap_audio, snap_resp, csp_pkg::PAD_BYTE};
				serial_output_line <= snap_audio[15];
			end else begin
				tx_sh              <= tx_sh << 1;
				serial_output_line <= tx_sh[30];
			end
		end
	end

	// Receive: audio slot then control word, MSB first
	always_ff @(posedge osc_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_sh     <= 32'h0000_0000;
			rx_word   <= 32'h0000_0000;
			frame_tog <= 1'b0;
		end else if (state == csp_pkg::LK_RUN && tick_samp) begin
			rx_sh <= {rx_sh[30:0], serial_input_line_s};
			if (bit_cnt == csp_pkg::BIT_LAST) begin
				rx_word   <= {rx_sh[30:0], serial_input_line_s};
				frame_tog <= ~frame_tog;
			end
		end
	end

	// Core domain (core_clk)
	logic                  tog_m, tog_s, tog_q, low_m, low_s;
	logic                  evt;
	logic [23:0]           por_cnt;
	logic [12:0]           brown_cnt;
	logic                  gate_now;
	csp_pkg::csp_ctrl_s    ctrl;
	csp_pkg::csp_dac_mode_e dac_mode;
	logic [2:0]            shift_sel;

	assign evt       = tog_s ^ tog_q;
	assign ctrl      = csp_pkg::csp_ctrl_s'(rx_word[11:0]);
	assign dac_mode  = csp_pkg::csp_dac_mode_e'(regs.hpfsft[1:0]);
	assign shift_sel = regs.hpfsft[csp_pkg::SHIFT_LSB +: 3];
	// Feed reads this, not the flop, so no sample slips out a cycle late
	assign gate_now  = !port_active || brown_cnt == 13'(BROWN_CYCLES);

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tog_m <= 1'b0;
			tog_s <= 1'b0;
			tog_q <= 1'b0;
			low_m <= 1'b0;
			low_s <= 1'b0;
		end else begin
			tog_m <= frame_tog;
			tog_s <= tog_m;
			tog_q <= tog_s;
			low_m <= supply_low;
			low_s <= low_m;
		end
	end

	// Power-valid wait after power-on reset
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			por_cnt     <= 24'h00_0000;
			port_active <= 1'b0;
		end else if (por_cnt == 24'(POR_VALID_CYCLES - 1))
			port_active <= 1'b1;
		else
			por_cnt <= por_cnt + 24'h00_0001;
	end

	// Supply drop filter; brief dips pass
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			brown_cnt      <= 13'h0000;
			modulator_gate <= 1'b1;
		end else begin
			if (!low_s)
				brown_cnt <= 13'h0000;
			else if (brown_cnt != 13'(BROWN_CYCLES))
				brown_cnt <= brown_cnt + 13'h0001;
			modulator_gate <= gate_now;
		end
	end

	// Register file; reserved addresses take no write
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			regs.pgac   <= csp_pkg::RST_PGAC;
			regs.hpfsft <= csp_pkg::RST_HPFSFT;
			regs.pdc    <= csp_pkg::RST_PDC;
			regs.fastar <= csp_pkg::RST_FASTAR;
			regs.slowar <= csp_pkg::RST_SLOWAR;
		end else if (evt && port_active && ctrl.rw) begin
			case (ctrl.addr)
				csp_pkg::ADDR_PGAC:   regs.pgac   <= ctrl.data;
				csp_pkg::ADDR_HPFSFT: regs.hpfsft <= ctrl.data;
				csp_pkg::ADDR_PDC:    regs.pdc    <= ctrl.data;
				csp_pkg::ADDR_FASTAR: regs.fastar <= ctrl.data;
				csp_pkg::ADDR_SLOWAR: regs.slowar <= ctrl.data;
				default:              regs.pgac   <= regs.pgac;
			endcase
		end
	end

	// Read response and outgoing sample, both sent in a later frame
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			adc_hold <= 16'h0000;
			tx_audio <= 16'h0000;
			resp     <= 8'h00;
		end else begin
			if (adc_valid)
				adc_hold <= adc_data;
			if (evt) begin
				tx_audio <= adc_hold;
				if (ctrl.addr != csp_pkg::ADDR_NONE && !ctrl.rw)
					resp <= read_reg(regs, ctrl.addr, pgac_gain_actual);
				else
					resp <= csp_pkg::READ_ZERO;
			end
		end
	end

	// Modulator feed
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dac_data  <= 20'h0_0000;
			dac_valid <= 1'b0;
		end else begin
			dac_valid <= evt && !gate_now &&
				dac_mode != csp_pkg::DAC_OFF;
			if (!evt)
				dac_data <= dac_data;
			else if (gate_now)
				dac_data <= 20'h0_0000;
			else
				case (dac_mode)
					csp_pkg::DAC_16:
						dac_data <= shift_sample(
							rx_word[csp_pkg::RX_S16_LSB +: 16], shift_sel);
					csp_pkg::DAC_20:
						dac_data <= rx_word[csp_pkg::RX_AUDIO_LSB +: 20];
					csp_pkg::DAC_LOOP:
						dac_data <= shift_sample(adc_hold, shift_sel);
					default: dac_data <= 20'h0_0000;
				endcase
		end
	end

	// Checks, link domain
	property p_mclk_toggle;
		@(posedge osc_clk) disable iff (sys_rst)
		1'b1 |=> mclk != $past(mclk);
	endproperty
	a_mclk_toggle: assert property (p_mclk_toggle)
		else $error("clock output did not toggle");

	property p_sclk_shape;
		@(posedge osc_clk) disable iff (sys_rst)
		state == csp_pkg::LK_RUN && div == 3'h3 |=> sclk [*4] ##1 !sclk;
	endproperty
	a_sclk_shape: assert property (p_sclk_shape)
		else $error("shift clock high phase wrong");

	property p_dsp_frame;
		@(posedge osc_clk) disable iff (sys_rst)
		state == csp_pkg::LK_RUN && !mode_spi && tick_shift
			&& bit_cnt == csp_pkg::BIT_HALF |=> !frame_sync [*8];
	endproperty
	a_dsp_frame: assert property (p_dsp_frame)
		else $error("codec frame not low in second half");

	property p_spi_low;
		@(posedge osc_clk) disable iff (sys_rst)
		state == csp_pkg::LK_RUN && mode_spi |-> !frame_sync;
	endproperty
	a_spi_low: assert property (p_spi_low)
		else $error("SPI frame line high during transfer");

	property p_pre_pulse;
		@(posedge osc_clk) disable iff (sys_rst)
		state == csp_pkg::LK_PRE && tick_shift
			&& bit_cnt == csp_pkg::PRE_PULSE |=> frame_sync ##8 !frame_sync;
	endproperty
	a_pre_pulse: assert property (p_pre_pulse)
		else $error("slave reset pulse missing");

	property p_msb_first;
		@(posedge osc_clk) disable iff (sys_rst)
		state == csp_pkg::LK_RUN && tick_shift && bit_cnt == csp_pkg::BIT_FIRST
			|=> serial_output_line == $past(snap_audio[15]);
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("first output bit not sample MSB");

	// Checks, core domain
	property p_zero_addr;
		@(posedge core_clk) disable iff (sys_rst)
		evt && ctrl.addr == csp_pkg::ADDR_NONE
			|=> regs == $past(regs) && resp == csp_pkg::READ_ZERO;
	endproperty
	a_zero_addr: assert property (p_zero_addr)
		else $error("zero address touched registers");

	property p_write_pdc;
		@(posedge core_clk) disable iff (sys_rst)
		evt && port_active && ctrl.rw && ctrl.addr == csp_pkg::ADDR_PDC
			|=> regs.pdc == $past(rx_word[7:0]);
	endproperty
	a_write_pdc: assert property (p_write_pdc)
		else $error("register write lost");

	property p_reserved_read;
		@(posedge core_clk) disable iff (sys_rst)
		evt && !ctrl.rw && ctrl.addr > csp_pkg::ADDR_SLOWAR
			|=> resp == csp_pkg::READ_ZERO;
	endproperty
	a_reserved_read: assert property (p_reserved_read)
		else $error("reserved address read nonzero");

	property p_dac20;
		@(posedge core_clk) disable iff (sys_rst)
		evt && !modulator_gate && dac_mode == csp_pkg::DAC_20
			|=> dac_valid && dac_data == $past(rx_word[31:12]);
	endproperty
	a_dac20: assert property (p_dac20)
		else $error("20-bit sample not passed through");

	property p_gate;
		@(posedge core_clk) disable iff (sys_rst)
		brown_cnt == 13'(BROWN_CYCLES) |=> modulator_gate && !dac_valid;
	endproperty
	a_gate: assert property (p_gate)
		else $error("modulator not gated on supply drop");

	property p_idle_until_valid;
		@(posedge core_clk) disable iff (sys_rst)
		!port_active |-> !dac_valid && modulator_gate;
	endproperty
	a_idle_until_valid: assert property (p_idle_until_valid)
		else $error("modulator fed before supply valid");

endmodule

`default_nettype wire

//--- verification/csp_partner.sv
/* Partner serial port model: shifts a 32-bit word into the codec's input
   line and captures the 24-bit output frame.
   Assumes the codec is link master and drives sclk and frame_sync. */
`default_nettype none
module csp_partner (
	// Link pins
	input  wire logic        sclk,
	input  wire logic        frame_sync,
	input  wire logic        serial_output_line,
	output logic             serial_input_line,
	// Bench side; the bench never puts a reserved write here
	input  wire logic [31:0] tx_word,
	output logic [23:0]      rx_word,
	output int               frames
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [4:0]  idx = 5'h00;
	logic        fs_q = 1'b0;
	logic [23:0] sh = 24'h000000;
	logic [31:0] cur = 32'h00000000;

	initial begin
		serial_input_line = 1'b0;
		rx_word = 24'h000000;
		frames = 0;
	end

	// Five-bit index wraps every 32 slots, frame rise resyncs it
	always @(posedge sclk) begin
		logic [4:0] i;
		i = (frame_sync && !fs_q) ? 5'h00 : idx;
		// One-slot pulse is the SPI slave reset; data starts four slots on
		if (!frame_sync && fs_q && idx == 5'h01)
			i = 5'h1C;
		fs_q = frame_sync;
		sh = {sh[22:0], serial_output_line};
		if (i == 5'h17)
			rx_word = sh;
		if (i == 5'h1F) begin
			frames++;
			// Whole frames only: a bench change lands at a frame edge
			cur = tx_word;
		end
		idx = i + 5'h01;
	end

	// Change on the fall so the bit is settled long before the rise
	always @(negedge sclk)
		serial_input_line = cur[5'h1F - idx];
endmodule
`default_nettype wire

//--- verification/testbench.sv
/* Bench for the codec serial port: clocks, reset, partner model and one
   task per scenario.
   Assumes the design package, port and partner model are compiled first. */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	// Shortened power-on and brown-out counts keep the run brief
	localparam int unsigned POR_CYC = 20;
	localparam int unsigned BRN_CYC = 10;

	logic                core_clk;
	logic                osc_clk;
	logic                sys_rst;
	logic                protocol_select_pin;
	logic                serial_input_line;
	logic                sclk;
	logic                frame_sync;
	logic                serial_output_line;
	logic                mclk;
	logic [15:0]         adc_data;
	logic                adc_valid;
	logic [6:0]          pgac_gain_actual;
	logic                supply_low;
	logic [19:0]         dac_data;
	logic                dac_valid;
	logic                modulator_gate;
	logic                port_active;
	csp_pkg::csp_regs_s  regs;
	logic [31:0]         tx_word;
	logic [23:0]         rx_word;
	int                  frames;
	int                  num_errors = 0;
	int                  check_count = 0;
	logic [7:0]          mval [4] = '{8'h5A, 8'h05, 8'h13, 8'h04};
	logic [19:0]         mdac [4] = '{20'h12345, 20'h02468, 20'h01230, 20'h0};
	logic [11:0]         rctl [8] = '{12'hB3C, 12'h1FF, 12'h4FF, 12'h6FF,
		12'h0FF, 12'h3FF, 12'h9C6, 12'h1FF};
	logic [7:0]          rexp [8] = '{8'h00, 8'h46, 8'hF7, 8'h00,
		8'h00, 8'h3C, 8'h00, 8'hAA};

	csp_port #(
		.POR_VALID_CYCLES (POR_CYC),
		.BROWN_CYCLES     (BRN_CYC)
	) csp_port_inst (
		.core_clk            (core_clk),
		.osc_clk             (osc_clk),
		.sys_rst             (sys_rst),
		.protocol_select_pin (protocol_select_pin),
		.serial_input_line   (serial_input_line),
		.sclk                (sclk),
		.frame_sync          (frame_sync),
		.serial_output_line  (serial_output_line),
		.mclk                (mclk),
		.adc_data            (adc_data),
		.adc_valid           (adc_valid),
		.pgac_gain_actual    (pgac_gain_actual),
		.supply_low          (supply_low),
		.dac_data            (dac_data),
		.dac_valid           (dac_valid),
		.modulator_gate      (modulator_gate),
		.port_active         (port_active),
		.regs                (regs)
	);

	csp_partner csp_partner_inst (
		.sclk               (sclk),
		.frame_sync         (frame_sync),
		.serial_output_line (serial_output_line),
		.serial_input_line  (serial_input_line),
		.tx_word            (tx_word),
		.rx_word            (rx_word),
		.frames             (frames)
	);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	initial begin
		osc_clk = 1'b0;
		#1.7;
		forever #3 osc_clk = ~osc_clk;
	end

	task automatic wrap_up();
		$display("checks=%0d errors=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wait_frames(input int n);
		int f0;
		int k;
		f0 = frames;
		for (k = 0; k < 600 * n && frames < f0 + n; k++)
			@(posedge osc_clk);
		if (frames < f0 + n) begin
			chk(40'h1, 40'h0);
			wrap_up();
		end
	endtask

	// Length in osc cycles of the next run of lvl on sclk or frame_sync
	task automatic run_len(input bit sel, input logic lvl, output int n);
		int k;
		n = 0;
		for (k = 0; k < 600 && (sel ? sclk : frame_sync) !== lvl; k++)
			@(posedge osc_clk) #1;
		while ((sel ? sclk : frame_sync) === lvl && n < 600) begin
			@(posedge osc_clk) #1;
			n++;
		end
	endtask

	task automatic s_reset();
		int n;
		int flips;
		logic prev;
		chk(40'(regs), {csp_pkg::RST_PGAC, csp_pkg::RST_HPFSFT, csp_pkg::RST_PDC,
			csp_pkg::RST_FASTAR, csp_pkg::RST_SLOWAR});
		chk(40'(modulator_gate), 40'h1);
		for (n = 0; n < 100 && port_active !== 1'b1; n++)
			@(posedge core_clk) #1;
		chk(40'(n >= POR_CYC - 1 && n <= POR_CYC + 2), 40'h1);
		flips = 0;
		@(posedge osc_clk) #1;
		prev = mclk;
		repeat (8) begin
			@(posedge osc_clk) #1;
			flips += int'(mclk !== prev);
			prev = mclk;
		end
		chk(40'(flips), 40'h8);
		chk(40'(modulator_gate), 40'h0);
	endtask

	task automatic s_frame();
		int n;
		run_len(1'b0, 1'b0, n);
		run_len(1'b0, 1'b1, n);
		chk(40'(n), 40'h80);
		run_len(1'b0, 1'b0, n);
		chk(40'(n), 40'h80);
		run_len(1'b1, 1'b0, n);
		run_len(1'b1, 1'b1, n);
		chk(40'(n), 40'h4);
		run_len(1'b1, 1'b0, n);
		chk(40'(n), 40'h4);
	endtask

	task automatic s_modes();
		int i;
		int cnt;
		@(posedge core_clk);
		adc_data <= 16'h0123;
		adc_valid <= 1'b1;
		@(posedge core_clk);
		adc_valid <= 1'b0;
		for (i = 0; i < 4; i++) begin
			@(posedge core_clk);
			tx_word <= {20'h12345, 1'b1, csp_pkg::ADDR_HPFSFT, mval[i]};
			wait_frames(3);
			chk(40'(regs.hpfsft), 40'(mval[i]));
			cnt = 0;
			repeat (400) begin
				@(posedge core_clk) #1;
				cnt += int'(dac_valid === 1'b1);
			end
			chk(40'(cnt != 0), 40'(i != 3));
			if (i != 3)
				chk(40'(dac_data), 40'(mdac[i]));
		end
		chk(40'(regs.pgac), 40'(csp_pkg::RST_PGAC));
	endtask

	task automatic s_read();
		int i;
		for (i = 0; i < 8; i++) begin
			@(posedge core_clk);
			tx_word <= {20'h12345, rctl[i]};
			wait_frames(4);
			chk(40'(rx_word[7:0]), 40'(rexp[i]));
			chk(40'(rx_word[23:8]), 40'h0123);
		end
		chk(40'(regs.pdc), 40'h3C);
	endtask

	task automatic s_gate();
		int hi;
		@(posedge core_clk);
		hi = 0;
		supply_low <= 1'b1;
		repeat (BRN_CYC / 2) @(posedge core_clk);
		supply_low <= 1'b0;
		repeat (6) begin
			@(posedge core_clk) #1;
			hi += int'(modulator_gate !== 1'b0);
		end
		chk(40'(hi), 40'h0);
		@(posedge core_clk);
		supply_low <= 1'b1;
		repeat (BRN_CYC + 6) @(posedge core_clk);
		supply_low <= 1'b0;
		#1 chk(40'(modulator_gate), 40'h1);
		repeat (6) @(posedge core_clk);
		#1 chk(40'(modulator_gate), 40'h0);
	endtask

	task automatic s_spi();
		int n;
		int k;
		@(posedge core_clk);
		protocol_select_pin <= 1'b1;
		adc_data <= 16'h0456;
		adc_valid <= 1'b1;
		@(posedge core_clk);
		adc_valid <= 1'b0;
		// Start at a rise so no partial high run is counted
		run_len(1'b0, 1'b0, n);
		n = 0;
		for (k = 0; k < 6 && n != 8; k++)
			run_len(1'b0, 1'b1, n);
		chk(40'(n), 40'h8);
		run_len(1'b0, 1'b1, n);
		chk(40'(n), 40'h8);
		run_len(1'b0, 1'b0, n);
		chk(40'(n), 40'd600);
		wait_frames(4);
		chk(40'(rx_word), 40'h0456AA);
	endtask

	initial begin
		sys_rst = 1'b1;
		protocol_select_pin = 1'b0;
		adc_data = 16'h0000;
		adc_valid = 1'b0;
		pgac_gain_actual = 7'h2A;
		supply_low = 1'b0;
		tx_word = 32'h00000000;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		s_reset();
		s_frame();
		s_modes();
		s_read();
		s_gate();
		s_spi();
		wrap_up();
	end
endmodule
`default_nettype wire
